// [asp_serial_port.sv]
/*
  Asynchronous serial port with AXI4-Lite register access.
  Assumes pins sampled synchronous to clk_sys and one master at a time.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "asp_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: divisor is ten bits, high two from control two
// R2: zero divisor stops the baud clock
// R3: bit rate is clock over sixteen times divisor
// R4: control one bit 7 enables whole port
// R5: control one bit 6 enables transmitter
// R6: control one bit 5 enables receiver
// R7: control one bit 4 selects multiprocessor mode; the code stores the bit but nothing reads it
// R8: stop-width bit selects two or one stops
// R9: control two bit 4 swaps pins
// R10: interrupt enables gate flag requests
// R11: status bit 6 holds received ninth bit
// R12: status bit 5 transmitted ninth bit, parity
// R13: status bit 4 set when send buffer empties
// R14: status bit 3 set on new character
// R15: flags cleared by writing zero only
// R16: overflow sets bit 2, drops new data
// R17: bad stop bit sets framing bit 1
// R18: parity mismatch sets bit 0
// R19: one data address, separate buffers
// R20: nine or eight bits, odd or even parity
// R21: write sends start, data, ninth, stops
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int DIV_W = 10                   // Divisor width.
) (
  input  wire logic        clk_sys,          // System clock.
  input  wire logic        nrst,             // Synchronous reset, active low.
  input  wire logic [31:0] s_axi_awaddr,     // Write address.
  input  wire logic        s_axi_awvalid,    // Write address valid.
  output logic             s_axi_awready,    // Write address ready.
  input  wire logic [31:0] s_axi_wdata,      // Write data.
  input  wire logic [3:0]  s_axi_wstrb,      // Write strobes.
  input  wire logic        s_axi_wvalid,     // Write data valid.
  output logic             s_axi_wready,     // Write data ready.
  output logic [1:0]       s_axi_bresp,      // Write response.
  output logic             s_axi_bvalid,     // Write response valid.
  input  wire logic        s_axi_bready,     // Write response ready.
  input  wire logic [31:0] s_axi_araddr,     // Read address.
  input  wire logic        s_axi_arvalid,    // Read address valid.
  output logic             s_axi_arready,    // Read address ready.
  output logic [31:0]      s_axi_rdata,      // Read data.
  output logic [1:0]       s_axi_rresp,      // Read response.
  output logic             s_axi_rvalid,     // Read data valid.
  input  wire logic        s_axi_rready,     // Read data ready.
  input  wire logic        padA,             // Level on the normal receive pin.
  input  wire logic        padB,             // Level on the normal transmit pin.
  output logic             padAOut,          // Drive of the normal receive pin.
  output logic             padAOe,           // Enable of the normal receive pin.
  output logic             padBOut,          // Drive of the normal transmit pin.
  output logic             padBOe,           // Enable of the normal transmit pin.
  output logic             txIrq,            // Send buffer empty request.
  output logic             rxIrq             // Receive buffer full request.
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0]    divLow;
  asp_ctrl_one_t ctrlOne;
  asp_ctrl_two_t ctrlTwo;
  logic [7:0]    flags;
  logic [7:0]    rxBuf;
  logic [8:0]    txBuf;
  logic          txPend;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: a write is taken when address and data both stand.
  logic [31:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        awHeld;
  logic        wHeld;
  wire  logic  wrFire = awHeld && wHeld && !s_axi_bvalid;
  wire  logic [7:0] wrIdx = word_index(awAddr);
  wire  logic  wrLane = wrFire && wStrb[0];
  wire  logic  wrDiv  = wrLane && (wrIdx == `ASP_IDX_DIV_LOW);
  wire  logic  wrC1   = wrLane && (wrIdx == `ASP_IDX_CTRL_ONE);
  wire  logic  wrC2   = wrLane && (wrIdx == `ASP_IDX_CTRL_TWO);
  wire  logic  wrFlg  = wrLane && (wrIdx == `ASP_IDX_FLAGS);
  wire  logic  wrDat  = wrLane && (wrIdx == `ASP_IDX_DATA);
  wire  logic  wrOk   = (wrIdx >= `ASP_IDX_DIV_LOW) && (wrIdx <= `ASP_IDX_IRQ_STAT);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 32'h0;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Read path; a data port read returns the receive buffer only.
  wire logic [7:0] rdIdx = word_index(s_axi_araddr);
  wire logic       rdFire = s_axi_arvalid && s_axi_arready;
  wire logic [7:0] rdByte =
    (rdIdx == `ASP_IDX_DIV_LOW)  ? divLow :
    (rdIdx == `ASP_IDX_CTRL_ONE) ? ctrlOne :
    (rdIdx == `ASP_IDX_CTRL_TWO) ? ctrlTwo :
    (rdIdx == `ASP_IDX_FLAGS)    ? flags :
    (rdIdx == `ASP_IDX_DATA)     ? rxBuf :                               // R19
    (rdIdx == `ASP_IDX_IRQ_STAT) ? {6'h0, rxIrq, txIrq} : 8'h00;
  wire logic       rdOk = (rdIdx >= `ASP_IDX_DIV_LOW) && (rdIdx <= `ASP_IDX_IRQ_STAT);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rdByte};
        s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Baud tick at sixteen times the bit rate.
  wire logic [DIV_W-1:0] divisor = {ctrlTwo.divHigh, divLow};           // R1
  logic [DIV_W-1:0]      baudCnt;
  logic                  tick;
  wire  logic            baudRun = ctrlOne.portOn && (divisor != '0);  // R2 R4

  always_ff @(posedge clk_sys) begin
    if (!nrst || !baudRun) begin
      baudCnt <= '0;
      tick    <= 1'b0;
    end else if (baudCnt >= divisor - 1'b1) begin
      baudCnt <= '0;                                                    // R3
      tick    <= 1'b1;
    end else begin
      baudCnt <= baudCnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // Pin routing under the swap bit.
  wire logic rxPin = ctrlTwo.swap ? padB : padA;                        // R9
  logic      txLine;

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  asp_state_t txState;
  logic [3:0] txSub;
  logic [3:0] txBit;
  logic [8:0] txShift;
  wire  logic txGo = ctrlOne.portOn && ctrlOne.txOn;                   // R4 R5
  wire  logic [3:0] dataBits = 4'd8;
  wire  logic ninthUsed = ctrlOne.nine || ctrlOne.parEn;               // R20
  wire  logic txParity = ^txBuf[7:0] ^ ctrlOne.parOdd;                  // R20
  wire  logic txNinth  = ctrlOne.parEn ? txParity : flags[`ASP_F_TX9];  // R12
  wire  logic txLast   = (txSub == 4'(`ASP_OVERSAMPLE - 1));
  wire  logic txDone   = tick && txLast && (txState == ASP_STOP) &&
                         (txBit == (ctrlOne.stop2 ? 4'd1 : 4'd0));     // R8
  wire  logic txLoad   = txGo && tick && (txState == ASP_IDLE) && txPend; // R3

  always_ff @(posedge clk_sys) begin
    if (!nrst || !txGo) begin
      txState <= ASP_IDLE;
      txSub   <= 4'h0;
      txBit   <= 4'h0;
      txShift <= 9'h0;
      txLine  <= 1'b1;
    end else if (txLoad) begin
      txState <= ASP_START;                                             // R21
      txShift <= {txNinth, txBuf[7:0]};
      txSub   <= 4'h0;
      txBit   <= 4'h0;
      txLine  <= 1'b0;
    end else if (tick && txState != ASP_IDLE) begin
      txSub <= txSub + 4'h1;
      if (txLast) begin
        case (txState)
          ASP_START: begin
            txState <= ASP_DATA;
            txLine  <= txShift[0];
          end
          ASP_DATA: begin
            txShift <= {1'b0, txShift[8:1]};
            txBit   <= txBit + 4'h1;
            if (txBit == dataBits - 4'h1) begin
              txBit   <= 4'h0;
              txState <= ninthUsed ? ASP_NINTH : ASP_STOP;
              txLine  <= ninthUsed ? txShift[1] : 1'b1;
            end else begin
              txLine <= txShift[1];
            end
          end
          ASP_NINTH: begin
            txState <= ASP_STOP;
            txLine  <= 1'b1;
          end
          ASP_STOP: begin
            if (txDone) begin
              txState <= ASP_IDLE;
            end else begin
              txBit <= txBit + 4'h1;
            end
            txLine <= 1'b1;
          end
          default: txState <= ASP_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver samples at the middle of each bit.
  asp_state_t rxState;
  logic [3:0] rxSub;
  logic [3:0] rxBit;
  logic [8:0] rxShift;
  logic       rxDone;
  logic       rxFrameBad;
  logic       rxParBad;
  wire  logic rxGo  = ctrlOne.portOn && ctrlOne.rxOn;                  // R4 R6
  wire  logic rxMid = tick && (rxSub == 4'(`ASP_MID_TICK));
  wire  logic rxCalcPar = ^rxShift[7:0] ^ ctrlOne.parOdd;

  always_ff @(posedge clk_sys) begin
    if (!nrst || !rxGo) begin
      rxState    <= ASP_IDLE;
      rxSub      <= 4'h0;
      rxBit      <= 4'h0;
      rxShift    <= 9'h0;
      rxDone     <= 1'b0;
      rxFrameBad <= 1'b0;
      rxParBad   <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (rxState == ASP_IDLE) begin
        rxSub <= 4'h0;
        rxBit <= 4'h0;
        if (tick && !rxPin) begin
          rxState <= ASP_START;
        end
      end else if (tick) begin
        rxSub <= rxSub + 4'h1;
        if (rxMid) begin
          case (rxState)
            ASP_START: begin
              rxState  <= rxPin ? ASP_IDLE : ASP_DATA;
              rxParBad <= 1'b0;
            end
            ASP_DATA: begin
              rxShift <= {1'b0, rxPin, rxShift[7:1]};
              rxBit   <= rxBit + 4'h1;
              if (rxBit == dataBits - 4'h1) begin
                rxState <= ninthUsed ? ASP_NINTH : ASP_STOP;
              end
            end
            ASP_NINTH: begin
              rxShift[8] <= rxPin;
              rxParBad   <= ctrlOne.parEn && (rxPin != rxCalcPar);     // R18
              rxState    <= ASP_STOP;
            end
            ASP_STOP: begin
              rxFrameBad <= !rxPin;                                     // R17
              rxDone     <= 1'b1;
              rxState    <= ASP_IDLE;
            end
            default: rxState <= ASP_IDLE;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers, buffers and flags; hardware set wins over a clear.
  wire logic [7:0] wb = wData[7:0];
  wire logic [7:0] flagKeep = wrFlg ? wb : 8'hff;                       // R15
  wire logic       rxAccept = rxDone && !flags[`ASP_F_RXF];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      divLow  <= `ASP_RST_DIV_LOW;
      ctrlOne <= `ASP_RST_CTRL_ONE;
      ctrlTwo <= `ASP_RST_CTRL_TWO;
      flags   <= `ASP_RST_FLAGS;
      rxBuf   <= `ASP_RST_DATA;
      txBuf   <= 9'h0;
      txPend  <= 1'b0;
    end else begin
      if (wrDiv) begin
        divLow <= wb;
      end
      if (wrC1) begin
        ctrlOne <= wb;                                                  // R7
      end
      if (wrC2) begin
        ctrlTwo <= {3'b000, wb[4:0]};
      end
      if (wrDat && txGo) begin
        txBuf  <= {1'b0, wb};                                           // R19
        txPend <= 1'b1;
      end else if (txLoad) begin
        txPend <= 1'b0;
      end
      flags[`ASP_F_TXE] <= (flags[`ASP_F_TXE] & flagKeep[`ASP_F_TXE]) | txLoad; // R13
      flags[`ASP_F_RXF] <= (flags[`ASP_F_RXF] & flagKeep[`ASP_F_RXF]) | rxAccept; // R14
      flags[`ASP_F_OVR] <= (flags[`ASP_F_OVR] & flagKeep[`ASP_F_OVR]) |
                           (rxDone && flags[`ASP_F_RXF]);               // R16
      flags[`ASP_F_FRM] <= (flags[`ASP_F_FRM] & flagKeep[`ASP_F_FRM]) |
                           (rxAccept && rxFrameBad);                    // R17
      flags[`ASP_F_PAR] <= (flags[`ASP_F_PAR] & flagKeep[`ASP_F_PAR]) |
                           (rxAccept && rxParBad);                      // R18
      if (wrFlg && !ctrlOne.parEn) begin
        flags[`ASP_F_TX9] <= wb[`ASP_F_TX9];                            // R12
      end else if (txLoad && ctrlOne.parEn) begin
        flags[`ASP_F_TX9] <= txNinth;
      end
      if (rxAccept) begin
        rxBuf             <= rxShift[7:0];                              // R16
        flags[`ASP_F_RX9] <= rxShift[8];                                // R11
      end
      flags[7] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins and requests.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      padAOut <= 1'b1;
      padAOe  <= 1'b0;
      padBOut <= 1'b1;
      padBOe  <= 1'b0;
      txIrq   <= 1'b0;
      rxIrq   <= 1'b0;
    end else begin
      padAOut <= txLine;
      padBOut <= txLine;
      padAOe  <= txGo && ctrlTwo.swap;                                  // R9
      padBOe  <= txGo && !ctrlTwo.swap;
      txIrq   <= ctrlTwo.txIrqOn && flags[`ASP_F_TXE];                  // R10
      rxIrq   <= ctrlTwo.rxIrqOn && flags[`ASP_F_RXF];                  // R10
    end
  end

endmodule : asp_serial_port

// [asp_params.svh]
/*
  Offsets, field positions, reset values and timing figures of the serial port.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

`define ASP_IDX_DIV_LOW   8'hbd
`define ASP_IDX_CTRL_ONE  8'hbe
`define ASP_IDX_CTRL_TWO  8'hbf
`define ASP_IDX_FLAGS     8'hc0
`define ASP_IDX_DATA      8'hc1
`define ASP_IDX_IRQ_STAT  8'hc2

`define ASP_C1_PORT_ON    7
`define ASP_C1_TX_ON      6
`define ASP_C1_RX_ON      5
`define ASP_C1_MULTI      4
`define ASP_C1_STOP2      3
`define ASP_C1_NINE       2
`define ASP_C1_PAR_EN     1
`define ASP_C1_PAR_ODD    0

`define ASP_C2_SWAP       4
`define ASP_C2_TX_IRQ     3
`define ASP_C2_RX_IRQ     2

`define ASP_F_RX9         6
`define ASP_F_TX9         5
`define ASP_F_TXE         4
`define ASP_F_RXF         3
`define ASP_F_OVR         2
`define ASP_F_FRM         1
`define ASP_F_PAR         0

`define ASP_RST_DIV_LOW   8'h00
`define ASP_RST_CTRL_ONE  8'h00
`define ASP_RST_CTRL_TWO  8'h0c
`define ASP_RST_FLAGS     8'h00
`define ASP_RST_DATA      8'hff

`define ASP_OVERSAMPLE    16
`define ASP_MID_TICK      7

`endif

// [asp_pkg.sv]
/*
  Types shared by the serial port.
  Assumes asp_params.svh is available for constants.
*/
package asp_pkg;

  typedef enum logic [2:0] {
    ASP_IDLE  = 3'b000,
    ASP_START = 3'b001,
    ASP_DATA  = 3'b011,
    ASP_NINTH = 3'b010,
    ASP_STOP  = 3'b110
  } asp_state_t;

  typedef struct packed {
    logic portOn;
    logic txOn;
    logic rxOn;
    logic multi;
    logic stop2;
    logic nine;
    logic parEn;
    logic parOdd;
  } asp_ctrl_one_t;

  typedef struct packed {
    logic [2:0] spare;
    logic       swap;
    logic       txIrqOn;
    logic       rxIrqOn;
    logic [1:0] divHigh;
  } asp_ctrl_two_t;

endpackage : asp_pkg

// [asp_serial_port_properties.sv]
/* Concurrent checks on the serial port's pins, bit timing and bus.
   Bound to asp_serial_port; follows control writes seen on the bus. */
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_serial_port_properties
  import asp_pkg::*;
#(
  parameter int DIV_W = 10                 // Divisor width.
) (
  input wire logic        clk_sys,         // Clock.
  input wire logic        nrst,            // Reset.
  input wire logic [31:0] s_axi_awaddr,    // Bus.
  input wire logic        s_axi_awvalid,   // Bus.
  input wire logic        s_axi_awready,   // Bus.
  input wire logic [31:0] s_axi_wdata,     // Bus.
  input wire logic [3:0]  s_axi_wstrb,     // Bus.
  input wire logic        s_axi_wvalid,    // Bus.
  input wire logic        s_axi_wready,    // Bus.
  input wire logic [1:0]  s_axi_bresp,     // Bus.
  input wire logic        s_axi_bvalid,    // Bus.
  input wire logic        s_axi_bready,    // Bus.
  input wire logic [31:0] s_axi_araddr,    // Bus.
  input wire logic        s_axi_arvalid,   // Bus.
  input wire logic        s_axi_arready,   // Bus.
  input wire logic [31:0] s_axi_rdata,     // Bus.
  input wire logic [1:0]  s_axi_rresp,     // Bus.
  input wire logic        s_axi_rvalid,    // Bus.
  input wire logic        s_axi_rready,    // Bus.
  input wire logic        padA,            // Pin.
  input wire logic        padB,            // Pin.
  input wire logic        padAOut,         // Pin.
  input wire logic        padAOe,          // Pin.
  input wire logic        padBOut,         // Pin.
  input wire logic        padBOe,          // Pin.
  input wire logic        txIrq,           // Request.
  input wire logic        rxIrq            // Request.
);
  logic [31:0] wrAddr;
  logic [7:0]  wrData, divLow, ctrlOne, ctrlTwo;
  logic [15:0] lowRun;
  wire  [15:0] bitLen = {2'b00, ctrlTwo[1:0], divLow, 4'h0};
  wire         bPinOk = ctrlOne[`ASP_C1_TX_ON] & ~ctrlTwo[`ASP_C2_SWAP];
  wire         aPinOk = ctrlOne[`ASP_C1_TX_ON] & ctrlTwo[`ASP_C2_SWAP];
  wire         txMask = ctrlTwo[`ASP_C2_TX_IRQ];
  wire         rxMask = ctrlTwo[`ASP_C2_RX_IRQ];
  // Shadow copies lag the real registers by one write response.
  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wrData <= s_axi_wdata[7:0];
    lowRun <= padBOut ? 16'h0000 : lowRun + 16'h0001;
    if (!nrst) begin
      divLow <= `ASP_RST_DIV_LOW;
      ctrlOne <= `ASP_RST_CTRL_ONE;
      ctrlTwo <= `ASP_RST_CTRL_TWO;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (wrAddr == {22'h0, `ASP_IDX_DIV_LOW, 2'b00}) divLow <= wrData;
      if (wrAddr == {22'h0, `ASP_IDX_CTRL_ONE, 2'b00}) ctrlOne <= wrData;
      if (wrAddr == {22'h0, `ASP_IDX_CTRL_TWO, 2'b00}) ctrlTwo <= wrData;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  property p_pins_excl; !(padAOe && padBOe); endproperty
  a_pins_excl: assert property (p_pins_excl) else $error("Both pins driven.");
  property p_pin_a; padAOe |-> aPinOk || $past(aPinOk); endproperty
  a_pin_a: assert property (p_pin_a) else $error("Pin A driven unswapped.");
  property p_pin_b; padBOe |-> bPinOk || $past(bPinOk); endproperty
  a_pin_b: assert property (p_pin_b) else $error("Pin B driven with sender off.");
  property p_bit_time;
    padBOe && bitLen != 16'h0 && $rose(padBOut) |-> (lowRun % bitLen) == 16'h0;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("Low run not whole bits.");
  property p_tx_irq; txIrq |-> txMask || $past(txMask); endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("Send request while masked.");
  property p_rx_irq; rxIrq |-> rxMask || $past(rxMask); endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("Receive request while masked.");
  property p_read_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_ans: assert property (p_read_ans) else $error("Read answer late.");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("Write taken while answering.");
  c_swap: cover property ($rose(padAOe));
  c_rx_irq: cover property ($rose(rxIrq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : asp_serial_port_properties

// [asp_remote_device.sv]
/* Remote serial device facing the port's pins.
   Assumes the bench sets the bit length to match the programmed divisor. */
`timescale 1ns/1ps
module asp_remote_device
  import asp_pkg::*;
#(
  parameter int BIT_CYC = 32     // Clocks per bit.
) (
  input  wire logic clk_sys,     // Clock.
  input  wire logic rxLine,      // Line from the port.
  output logic      txLine       // Line to the port.
);
  int         rxBits  = 8;
  int         rxCount = 0;
  logic [8:0] rxWord;
  initial txLine = 1'b1;
  // Start bit, then the given bits least significant first; the line idles high.
  task automatic send(input logic [11:0] bits, input int nb);
    @(posedge clk_sys);
    txLine <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      txLine <= bits[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    txLine <= 1'b1;
  endtask : send
  initial forever begin
    @(negedge rxLine);
    rxWord = 9'h000;
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < rxBits; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      rxWord[i] = rxLine;
    end
    repeat (BIT_CYC) @(posedge clk_sys);
    rxCount++;
  end
endmodule : asp_remote_device

// [asp_serial_port_tb.sv]
/* Self-checking bench of the serial port: registers, framing, flags, pins.
   Assumes the remote model and the checker are compiled before it. */
`timescale 1ns/1ps
`include "asp_params.svh"
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value at %0t: %h instead of %h", $time, g, e); \
  end \
end
module asp_serial_port_tb import asp_pkg::*;;
  localparam int          BIT_CYC = 32;
  localparam logic [31:0] A_DIV   = {22'h0, `ASP_IDX_DIV_LOW, 2'b00};
  localparam logic [31:0] A_C1    = {22'h0, `ASP_IDX_CTRL_ONE, 2'b00};
  localparam logic [31:0] A_C2    = {22'h0, `ASP_IDX_CTRL_TWO, 2'b00};
  localparam logic [31:0] A_FLG   = {22'h0, `ASP_IDX_FLAGS, 2'b00};
  localparam logic [31:0] A_DAT   = {22'h0, `ASP_IDX_DATA, 2'b00};
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rdVal;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, swapSel = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        padAOut, padAOe, padBOut, padBOe, txIrq, rxIrq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp;
  int          mismatches = 0, total_checks = 0, cycles = 0, n;
  wire         remTx;
  // An undriven pin carries the remote's line if it faces the remote, and is pulled high otherwise.
  wire         pinA = padAOe ? padAOut : (swapSel ? 1'b1 : remTx);
  wire         pinB = padBOe ? padBOut : (swapSel ? remTx : 1'b1);
  asp_serial_port dut (
    .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .padA(pinA), .padB(pinB), .padAOut,
    .padAOe, .padBOut, .padBOe, .txIrq, .rxIrq
  );
  asp_remote_device #(.BIT_CYC(BIT_CYC)) remote (
    .clk_sys, .rxLine(swapSel ? pinA : pinB), .txLine(remTx)
  );
  ////////////////////////////////////////////////////////////////////////
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdVal, e)
  endtask : chk_reg
  task automatic flags(input logic [7:0] m, input logic [7:0] e);
    rd(A_FLG);
    `CHK(rdVal[7:0] & m, e)
  endtask : flags
  task automatic tx_byte(input logic [7:0] d);
    n = remote.rxCount;
    wr(A_DAT, d);
    for (int i = 0; i < 20 * BIT_CYC && remote.rxCount == n; i++) @(posedge clk_sys);
  endtask : tx_byte
  task automatic send_rx(input logic [11:0] bits, input int nb);
    remote.send(bits, nb);
    repeat (2 * BIT_CYC) @(posedge clk_sys);
  endtask : send_rx
  task automatic t_reset();
    chk_reg(A_DIV, 32'h00);
    chk_reg(A_C1, 32'h00);
    chk_reg(A_C2, 32'h0c);
    chk_reg(A_FLG, 32'h00);
    chk_reg(A_DAT, 32'hff);
    rd(32'h3f0);
    `CHK(rdResp, 2'b10)
    $display("reset test done");
  endtask : t_reset
  task automatic t_transmit();
    wr(A_DIV, 8'h02);
    wr(A_C1, 8'he0);
    tx_byte(8'ha5);
    `CHK(remote.rxWord[7:0], 8'ha5)
    chk_reg(A_FLG, 32'h10);
    `CHK(txIrq, 1'b1)
    wr(A_FLG, 8'h10);
    chk_reg(A_FLG, 32'h10);
    wr(A_FLG, 8'h00);
    chk_reg(A_FLG, 32'h00);
    `CHK(txIrq, 1'b0)
    wr(A_C1, 8'heb);
    remote.rxBits = 9;
    tx_byte(8'h3c);
    `CHK(remote.rxWord, 9'h13c)
    chk_reg(A_FLG, 32'h30);
    remote.rxBits = 8;
    wr(A_FLG, 8'h00);
    $display("transmit test done");
  endtask : t_transmit
  task automatic t_swap();
    wr(A_C1, 8'hf0);
    chk_reg(A_C1, 32'hf0);
    wr(A_C2, 8'h1c);
    swapSel <= 1'b1;
    tx_byte(8'h3c);
    `CHK(remote.rxWord[7:0], 8'h3c)
    `CHK({padAOe, padBOe}, 2'b10)
    wr(A_C2, 8'h0c);
    swapSel <= 1'b0;
    wr(A_FLG, 8'h00);
    $display("swap test done");
  endtask : t_swap
  task automatic t_disable();
    for (int i = 0; i < 2; i++) begin
      wr(A_C1, i == 0 ? 8'ha0 : 8'h60);
      tx_byte(8'h55);
      `CHK(remote.rxCount, n)
      `CHK(padBOe, 1'b0)
    end
    flags(8'h1f, 8'h00);
    $display("disable test done");
  endtask : t_disable
  task automatic t_receive();
    wr(A_C1, 8'heb);
    send_rx({3'b011, 1'b1, 8'h3c}, 11);
    flags(8'h1f, 8'h08);
    `CHK(rxIrq, 1'b1)
    chk_reg(A_DAT, 32'h3c);
    send_rx({3'b011, 1'b1, 8'h66}, 11);
    flags(8'h1f, 8'h0c);
    chk_reg(A_DAT, 32'h3c);
    wr(A_C2, 8'h08);
    chk_reg(A_C2, 32'h08);
    `CHK(rxIrq, 1'b0)
    wr(A_FLG, 8'h00);
    wr(A_C1, 8'hea);
    send_rx({3'b011, 1'b1, 8'h3c}, 11);
    flags(8'h1f, 8'h09);
    wr(A_FLG, 8'h00);
    send_rx({3'b000, 1'b0, 8'h3c}, 10);
    flags(8'h1f, 8'h0a);
    wr(A_FLG, 8'h00);
    wr(A_C2, 8'h0c);
    wr(A_C1, 8'he4);
    send_rx({3'b011, 1'b1, 8'h5a}, 10);
    flags(8'h5f, 8'h48);
    chk_reg(A_DAT, 32'h5a);
    $display("receive test done");
  endtask : t_receive
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_transmit();
    t_swap();
    t_disable();
    t_receive();
    close_out();
  end
endmodule : asp_serial_port_tb
bind asp_serial_port asp_serial_port_properties #(.DIV_W(DIV_W)) u_props (.*);
